// ===== hw/scu_serial_unit.v
/*
  Serial unit: AXI4-Lite register slave, base clock prescaler, transmit and
  receive baud counters, transmitter with one-deep buffer, receiver with a
  two-sample noise filter and error flags.
  Assumes one 40 MHz clock, synchronous active-low reset, and a serial input
  already synchronous to aclk.
*/
// Local design decisions: the AXI4-Lite register port and the register addresses.
`include "scu_defines.vh"

module scu_serial_unit
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg tx_complete_irq,
  output reg rx_complete_irq,
  output reg rx_error_irq
);

  // Control registers.
  reg [7:0] operation_mode_reg;
  reg [7:0] base_clock_select;
  reg [7:0] baud_divisor;
  wire unit_power_bit = operation_mode_reg[`SCU_MODE_POWER];
  wire tx_enable_bit = operation_mode_reg[`SCU_MODE_TXE];
  wire rx_enable_bit = operation_mode_reg[`SCU_MODE_RXE];
  wire error_irq_merge_bit = operation_mode_reg[`SCU_MODE_MERGE];
  wire [1:0] parity_mode = operation_mode_reg[`SCU_MODE_PAR_LO+1:`SCU_MODE_PAR_LO];
  wire len8 = operation_mode_reg[`SCU_MODE_LEN8];
  wire stop2 = operation_mode_reg[`SCU_MODE_STOP2];
  wire tx_on = unit_power_bit & tx_enable_bit;
  wire rx_on = unit_power_bit & rx_enable_bit;

  // Bus handshake state.
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire wr_lane0 = wr_fire & w_strb[0];

  // Transmit state.
  reg [7:0] transmit_buffer;
  reg [10:0] transmit_shift_reg;
  reg tx_buffer_full_flag;
  reg tx_shift_active_flag;
  reg [3:0] tx_bits_left;
  reg [7:0] tx_count;
  reg tx_half;

  // Receive state.
  reg [7:0] receive_buffer;
  reg [9:0] receive_shift_reg;
  reg [3:0] rx_bits_left;
  reg [7:0] rx_count;
  reg rx_half;
  reg rx_busy;
  reg rx_checking;
  reg rx_unread;
  reg overrun_flag;
  reg framing_flag;
  reg parity_error_flag;
  reg [1:0] rx_samp;
  reg rx_filt;
  reg rx_filt_d;

  // Base clock prescaler: enable pulse every 2^sel cycles, none while powered down.
  reg [10:0] pre_count;
  reg base_tick;
  wire [3:0] base_clock_sel_field = base_clock_select[3:0];
  wire [10:0] pre_limit = (11'h001 << base_clock_sel_field) - 11'h001;
  always @(posedge aclk)
  begin
    if (!aresetn || !unit_power_bit)
    begin
      pre_count <= 11'h000;
      base_tick <= 1'b0;
    end
    else if (pre_count >= pre_limit)
    begin
      pre_count <= 11'h000;
      base_tick <= 1'b1;
    end
    else
    begin
      pre_count <= pre_count + 11'h001;
      base_tick <= 1'b0;
    end
  end

  // The divisor counts base ticks; a bit lasts two divisor periods.
  wire [7:0] divisor_value_field = baud_divisor;
  wire tx_cnt_end = base_tick && (tx_count >= divisor_value_field - 8'h01);
  wire tx_bit_end = tx_cnt_end & tx_half;
  wire rx_cnt_end = base_tick && (rx_count >= divisor_value_field - 8'h01);
  wire rx_bit_end = rx_cnt_end & rx_half;

  // Parity over the character bits.
  wire [7:0] tx_char = len8 ? transmit_buffer : {1'b0, transmit_buffer[6:0]};
  wire tx_xor = ^tx_char;
  reg tx_par_bit;
  always @*
  begin
    case (parity_mode)
      `SCU_PAR_EVEN: tx_par_bit = tx_xor;
      `SCU_PAR_ODD: tx_par_bit = ~tx_xor;
      default: tx_par_bit = 1'b0;
    endcase
  end
  wire has_par = (parity_mode != `SCU_PAR_NONE);
  wire [3:0] tx_frame_bits = 4'h8 + {3'h0, len8} + {3'h0, has_par} + {3'h0, stop2};
  // Frame below start bit: char, parity, stops, padded with idle ones.
  reg [10:0] tx_frame;
  always @*
  begin
    tx_frame = 11'h7FF;
    if (len8)
      tx_frame[7:0] = transmit_buffer;
    else
      tx_frame[6:0] = transmit_buffer[6:0];
    if (has_par)
      tx_frame[{1'b0, 3'h7} + {3'h0, len8}] = tx_par_bit;
  end

  // Transmitter. A load frees the buffer at once so the next byte may follow.
  always @(posedge aclk)
  begin
    if (!aresetn || !tx_on)
    begin
      transmit_shift_reg <= 11'h7FF;
      tx_buffer_full_flag <= 1'b0;
      tx_shift_active_flag <= 1'b0;
      tx_bits_left <= 4'h0;
      tx_count <= 8'h00;
      tx_half <= 1'b0;
      serial_out_pin <= 1'b1;
      tx_complete_irq <= 1'b0;
    end
    else
    begin
      tx_complete_irq <= 1'b0;
      if (tx_cnt_end)
      begin
        tx_count <= 8'h00;
        tx_half <= ~tx_half;
      end
      else if (base_tick)
        tx_count <= tx_count + 8'h01;
      if (wr_lane0 && aw_addr == `SCU_OFF_TXBUF && !tx_buffer_full_flag)
        tx_buffer_full_flag <= 1'b1;
      if (tx_shift_active_flag && tx_bit_end)
      begin
        if (tx_bits_left == 4'h0)
        begin
          tx_shift_active_flag <= 1'b0;
          tx_complete_irq <= 1'b1;
        end
        else
        begin
          serial_out_pin <= transmit_shift_reg[0];
          transmit_shift_reg <= {1'b1, transmit_shift_reg[10:1]};
          tx_bits_left <= tx_bits_left - 4'h1;
        end
      end
      // Load when idle, or right at frame end so frames run back to back.
      if (tx_buffer_full_flag && (!tx_shift_active_flag || (tx_bit_end && tx_bits_left == 4'h0)))
      begin
        transmit_shift_reg <= tx_frame;
        tx_bits_left <= tx_frame_bits;
        serial_out_pin <= 1'b0;
        tx_shift_active_flag <= 1'b1;
        tx_buffer_full_flag <= 1'b0;
        tx_count <= 8'h00;
        tx_half <= 1'b0;
      end
    end
  end

  // Noise filter: output moves only when two successive samples agree.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_samp <= 2'h3;
      rx_filt <= 1'b1;
      rx_filt_d <= 1'b1;
    end
    else
    begin
      rx_samp <= {rx_samp[0], serial_in_pin};
      if (rx_samp[1] == rx_samp[0])
        rx_filt <= rx_samp[1];
      rx_filt_d <= rx_filt;
    end
  end

  // Receive checks use the frame fields that are sampled.
  wire [3:0] rx_frame_bits = 4'h8 + {3'h0, len8} + {3'h0, has_par};
  wire rx_stop = rx_filt;
  wire [7:0] rx_char = len8 ? receive_shift_reg[9:2] : {1'b0, receive_shift_reg[9:3]};
  wire rx_par = receive_shift_reg[9];
  wire [7:0] rx_char_p = len8 ? receive_shift_reg[8:1] : {1'b0, receive_shift_reg[8:2]};
  wire rx_char_sel = has_par;
  wire [7:0] rx_data = rx_char_sel ? rx_char_p : rx_char;
  wire rx_xor = ^rx_data ^ rx_par;
  wire rx_par_bad = (parity_mode == `SCU_PAR_EVEN && rx_xor) || (parity_mode == `SCU_PAR_ODD && !rx_xor);
  wire rd_rxbuf = rd_fire && s_axi_araddr == `SCU_OFF_RXBUF;
  wire rd_rxerr = rd_fire && s_axi_araddr == `SCU_OFF_RXERR;
  // Character as it stands once the stop bit position is reached.
  wire [9:0] rx_last = {rx_filt, receive_shift_reg[9:1]};
  wire [7:0] rx_data_next = has_par ? (len8 ? rx_last[7:0] : {1'b0, rx_last[7:1]}) :
                            (len8 ? rx_last[8:1] : {1'b0, rx_last[8:2]});

  // Receiver: start check after one divisor count, then one bit period apart.
  always @(posedge aclk)
  begin
    if (!aresetn || !rx_on)
    begin
      rx_busy <= 1'b0;
      rx_checking <= 1'b0;
      rx_count <= 8'h00;
      rx_half <= 1'b0;
      rx_bits_left <= 4'h0;
      receive_shift_reg <= 10'h000;
      rx_complete_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      if (!aresetn)
      begin
        receive_buffer <= 8'h00;
        rx_unread <= 1'b0;
        overrun_flag <= 1'b0;
        framing_flag <= 1'b0;
        parity_error_flag <= 1'b0;
      end
    end
    else
    begin
      rx_complete_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      if (rd_rxbuf)
        rx_unread <= 1'b0;
      if (rd_rxerr)
      begin
        overrun_flag <= 1'b0;
        framing_flag <= 1'b0;
        parity_error_flag <= 1'b0;
      end
      if (rx_busy || rx_checking)
      begin
        if (rx_cnt_end)
        begin
          rx_count <= 8'h00;
          rx_half <= ~rx_half;
        end
        else if (base_tick)
          rx_count <= rx_count + 8'h01;
      end
      if (!rx_busy && !rx_checking && rx_filt_d && !rx_filt)
      begin
        rx_checking <= 1'b1;
        rx_count <= 8'h00;
        rx_half <= 1'b0;
      end
      else if (rx_checking && rx_cnt_end)
      begin
        rx_checking <= 1'b0;
        if (!rx_filt)
        begin
          rx_busy <= 1'b1;
          rx_half <= 1'b0;
          rx_bits_left <= rx_frame_bits;
        end
      end
      else if (rx_busy && rx_bit_end)
      begin
        receive_shift_reg <= {rx_filt, receive_shift_reg[9:1]};
        rx_bits_left <= rx_bits_left - 4'h1;
        if (rx_bits_left == 4'h1)
        begin
          // Stop bit sample: frame is done, any error still ends at the stop position.
          rx_busy <= 1'b0;
          rx_count <= 8'h00;
          rx_complete_irq <= 1'b1;
          if (!rx_stop)
            framing_flag <= 1'b1;
          if (rx_par_bad)
            parity_error_flag <= 1'b1;
          if (rx_unread)
            overrun_flag <= 1'b1;
          else
          begin
            receive_buffer <= rx_data_next;
            rx_unread <= 1'b1;
          end
          if ((!rx_stop || rx_par_bad || rx_unread) && !error_irq_merge_bit)
          begin
            rx_error_irq <= 1'b1;
            rx_complete_irq <= 1'b0;
          end
        end
      end
    end
  end

  // Write path: address and data are latched independently, then applied.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCU_RESP_OKAY;
      operation_mode_reg <= `SCU_MODE_RST;
      base_clock_select <= `SCU_CKSEL_RST;
      baud_divisor <= `SCU_DIV_RST;
      transmit_buffer <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SCU_RESP_OKAY;
        case (aw_addr)
          `SCU_OFF_MODE: if (w_strb[0]) operation_mode_reg <= w_data[7:0];
          `SCU_OFF_CKSEL: if (w_strb[0] && w_data[3:0] <= `SCU_CKSEL_MAX) base_clock_select <= {4'h0, w_data[3:0]};
          `SCU_OFF_DIV: if (w_strb[0] && w_data[7:0] >= `SCU_DIV_MIN) baud_divisor <= w_data[7:0];
          `SCU_OFF_TXBUF: if (w_strb[0] && !tx_buffer_full_flag && tx_on) transmit_buffer <= w_data[7:0];
          `SCU_OFF_RXBUF, `SCU_OFF_TXSTAT, `SCU_OFF_RXERR: s_axi_bresp <= `SCU_RESP_OKAY;
          default: s_axi_bresp <= `SCU_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read path: one cycle from address acceptance to data.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCU_RESP_OKAY;
    end
    else
    begin
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SCU_RESP_OKAY;
        case (s_axi_araddr)
          `SCU_OFF_MODE: s_axi_rdata <= {24'h000000, operation_mode_reg};
          `SCU_OFF_CKSEL: s_axi_rdata <= {24'h000000, base_clock_select};
          `SCU_OFF_DIV: s_axi_rdata <= {24'h000000, baud_divisor};
          `SCU_OFF_TXBUF: s_axi_rdata <= {24'h000000, transmit_buffer};
          `SCU_OFF_RXBUF: s_axi_rdata <= {24'h000000, receive_buffer};
          `SCU_OFF_TXSTAT: s_axi_rdata <= {30'h00000000, tx_buffer_full_flag, tx_shift_active_flag};
          `SCU_OFF_RXERR: s_axi_rdata <= {29'h00000000, parity_error_flag, framing_flag, overrun_flag};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCU_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // scu_serial_unit

// ===== hw/scu_defines.vh
/*
  Constants for the serial unit: register byte offsets, field positions,
  reset values and encodings.
  Assumes it is included by bare name from the serial unit design file.
*/
`ifndef SCU_DEFINES_VH
`define SCU_DEFINES_VH

// Register byte offsets on the AXI4-Lite bus.
`define SCU_OFF_MODE 8'h00
`define SCU_OFF_CKSEL 8'h04
`define SCU_OFF_DIV 8'h08
`define SCU_OFF_TXBUF 8'h0C
`define SCU_OFF_RXBUF 8'h10
`define SCU_OFF_TXSTAT 8'h14
`define SCU_OFF_RXERR 8'h18

// Mode register fields.
`define SCU_MODE_MERGE 0
`define SCU_MODE_STOP2 1
`define SCU_MODE_LEN8 2
`define SCU_MODE_PAR_LO 3
`define SCU_MODE_RXE 5
`define SCU_MODE_TXE 6
`define SCU_MODE_POWER 7

// Parity field encodings.
`define SCU_PAR_NONE 2'h0
`define SCU_PAR_ZERO 2'h1
`define SCU_PAR_ODD 2'h2
`define SCU_PAR_EVEN 2'h3

// Transmission status bit positions.
`define SCU_TXS_SHIFT 0
`define SCU_TXS_FULL 1

// Reception error status bit positions.
`define SCU_ERR_OVR 0
`define SCU_ERR_FRM 1
`define SCU_ERR_PAR 2

// Reset values and write limits.
`define SCU_MODE_RST 8'h01
`define SCU_CKSEL_RST 8'h00
`define SCU_DIV_RST 8'hFF
`define SCU_DIV_MIN 8'h04
`define SCU_CKSEL_MAX 4'hA

// AXI responses.
`define SCU_RESP_OKAY 2'h0
`define SCU_RESP_SLVERR 2'h2

`endif

// ===== tb/scu_serial_unit_sva.sv
/* Port checker for the serial unit: bus answers, line timing, interrupt pulses.
   Assumes it is bound into scu_serial_unit and sees only its ports. */
module scu_serial_unit_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire serial_out_pin,
  input wire tx_complete_irq,
  input wire rx_complete_irq,
  input wire rx_error_irq
);
  // All checks share the bus clock; all but chk_reset_idle stay quiet during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write whose address and data are taken at the same edge.
  sequence joint_write;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // The shortest legal low level: one bit of the smallest divisor.
  sequence low_bit;
    !serial_out_pin [*8];
  endsequence
  chk_write_answer:
    assert property (joint_write |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  chk_resp_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready) else $error("write resp dropped");
  chk_rdata_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_low_width:
    assert property ($fell(serial_out_pin) |-> low_bit) else $error("line low too short");
  chk_tx_after_stop:
    assert property (tx_complete_irq |-> $past(serial_out_pin) && $past(serial_out_pin, 2))
      else $error("tx done off stop");
  chk_tx_pulse:
    assert property ($rose(tx_complete_irq) |=> !tx_complete_irq) else $error("tx done not a pulse");
  chk_irq_split:
    assert property (rx_error_irq |-> !rx_complete_irq) else $error("error and done together");
  chk_rx_pulse:
    assert property (rx_complete_irq |=> !rx_complete_irq) else $error("rx done not a pulse");
  chk_reset_idle:
    assert property (disable iff (1'h0) !aresetn |=> serial_out_pin && !rx_error_irq && !s_axi_bvalid)
      else $error("outputs not idle after reset");
endmodule // scu_serial_unit_sva

bind scu_serial_unit scu_serial_unit_sva chk_i (.*);

// ===== tb/scu_remote_uart.sv
/* Remote serial end: sends frames into the unit and decodes what it sends.
   Assumes 8 data bits, odd parity and a bit period of BIT clocks. */
module scu_remote_uart #(parameter int BIT = 8) (
  input wire logic aclk,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  logic [9:0] rx_w;
  logic [9:0] got_q[$];
  // The line idles high, as a pulled-up wire would.
  initial line_to_dut = 1'h1;
  // One frame, least significant bit first; parity or stop spoilt on request.
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, ~^d ^ bad_par, d, 1'h0};
    for (int i = 0; i < 11; i++)
    begin
      line_to_dut <= f[i];
      repeat (BIT) @(posedge aclk);
    end
    if (bad_stop)
      line_to_dut <= 1'h1;
  endtask
  // A short low pulse, too brief to count as a start bit.
  task automatic glitch(input int n);
    line_to_dut <= 1'h0;
    repeat (n) @(posedge aclk);
    line_to_dut <= 1'h1;
  endtask
  // Decode at mid-bit; stored as stop level, parity good, data.
  initial forever
  begin
    @(negedge line_from_dut);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT) @(posedge aclk);
      rx_w[i] = line_from_dut;
    end
    got_q.push_back({rx_w[9], ^rx_w[8:0], rx_w[7:0]});
  end
endmodule // scu_remote_uart

// ===== tb/scu_serial_unit_tb.sv
/* Testbench for the serial unit: registers, continuous sending, reception errors.
   Assumes the remote end model and a bit period of 8 clocks (divisor 4, select 0). */
module scu_serial_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} scu_row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, sin, sout, txi, rxi, rei;
  logic [1:0] bresp, rresp, rs;
  int n_mismatch = 0, comparisons = 0, n_tx = 0, n_rx = 0, n_re = 0;
  scu_row_t rows [16] = '{
    '{1'h0, 8'h00, 32'h01, 2'h0}, '{1'h0, 8'h04, 32'h00, 2'h0}, '{1'h0, 8'h08, 32'hFF, 2'h0},
    '{1'h1, 8'h08, 32'h03, 2'h0},
    '{1'h0, 8'h08, 32'hFF, 2'h0},
    '{1'h1, 8'h08, 32'h04, 2'h0}, '{1'h0, 8'h08, 32'h04, 2'h0},
    '{1'h1, 8'h04, 32'h0B, 2'h0},
    '{1'h0, 8'h04, 32'h00, 2'h0},
    '{1'h1, 8'h04, 32'h00, 2'h0},
    '{1'h1, 8'h0C, 32'h55, 2'h0},
    '{1'h0, 8'h14, 32'h00, 2'h0},
    '{1'h0, 8'h1C, 32'h00, 2'h2}, '{1'h1, 8'h1C, 32'h00, 2'h2},
    '{1'h1, 8'h00, 32'hD4, 2'h0}, '{1'h0, 8'h00, 32'hD4, 2'h0}};

  // Half-period toggle gives the 25 ns clock.
  always #12.5 aclk = ~aclk;
  // Interrupt pulses are counted so that missing or extra ones show up.
  always @(posedge aclk)
  begin
    n_tx += (txi === 1'h1);
    n_rx += (rxi === 1'h1);
    n_re += (rei === 1'h1);
  end

  scu_serial_unit uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_in_pin(sin),
    .serial_out_pin(sout), .tx_complete_irq(txi), .rx_complete_irq(rxi), .rx_error_irq(rei));
  scu_remote_uart #(.BIT(8)) rem (.aclk(aclk), .line_from_dut(sout), .line_to_dut(sin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    rs = bresp;
    chk({31'h0, bvalid}, 32'h1, "write answer");
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    rready <= 1'h0;
    rd = rdata;
    rs = rresp;
    chk({31'h0, rvalid}, 32'h1, "read answer");
    @(posedge aclk);
  endtask
  // Reads status until the masked bits match; the host polls before writing the second byte.
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      rdr(8'h14);
      n++;
    end while ((rd & m) !== e && n < 200);
  endtask
  // One incoming frame, then error status read before the buffer.
  task automatic rxf(input logic [7:0] d, input logic bp, input logic bs, input logic [31:0] e, input logic cb);
    rem.send(d, bp, bs);
    repeat (16) @(posedge aclk);
    rdr(8'h18);
    chk(rd, e, "error status");
    rdr(8'h10);
    if (cb) chk(rd, {24'h0, d}, "receive buffer");
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang costs a mismatch; the whole run needs about 1100 clocks.
  initial
  begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rdr(rows[i].a);
      if (!rows[i].w && rows[i].r === 2'h0) chk(rd, rows[i].d, "register read");
      chk({30'h0, rs}, {30'h0, rows[i].r}, "bus response");
    end
    rem.send(8'h77, 1'h0, 1'h0);
    repeat (16) @(posedge aclk);
    chk(n_rx + n_re, 0, "reception while disabled");
    chk(rem.got_q.size(), 0, "frame from refused write");
    wr(8'h00, 32'hF4);
    rem.glitch(1);
    repeat (8) @(posedge aclk);
    rem.glitch(2);
    repeat (40) @(posedge aclk);
    chk(n_rx + n_re, 0, "glitch taken as frame");
    wr(8'h0C, 32'hA5);
    poll(32'h2, 32'h0);
    wr(8'h0C, 32'h3C);
    rdr(8'h14);
    chk(rd, 32'h3, "both flags set");
    poll(32'h2, 32'h0);
    chk(rd, 32'h1, "second frame shifting");
    poll(32'h1, 32'h0);
    chk(rd, 32'h0, "sending finished");
    chk(n_tx, 2, "completion pulses");
    chk(rem.got_q.size(), 2, "frames on line");
    chk(rem.got_q.pop_front(), 32'h3A5, "first frame");
    chk(rem.got_q.pop_front(), 32'h33C, "second frame");
    rxf(8'h5A, 1'h0, 1'h0, 32'h0, 1'h1);
    rxf(8'hC3, 1'h1, 1'h0, 32'h4, 1'h0);
    rdr(8'h18);
    chk(rd, 32'h0, "status cleared by read");
    rxf(8'h0F, 1'h0, 1'h1, 32'h2, 1'h0);
    wr(8'h00, 32'hF6);
    rem.send(8'h11, 1'h0, 1'h0);
    rxf(8'h11, 1'h0, 1'h0, 32'h1, 1'h1);
    chk(n_rx, 2, "completion with merge off");
    chk(n_re, 3, "error pulses");
    wr(8'h00, 32'hF5);
    rxf(8'h33, 1'h1, 1'h0, 32'h4, 1'h0);
    chk(n_rx, 3, "error on completion when merged");
    chk(n_re, 3, "no separate error when merged");
    summarize();
  end
endmodule // scu_serial_unit_tb
